// >>> logic/adc_seq_defs.svh
// Constants for the pair conversion sequencer
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

`define NUM_PAIRS 13
`define NUM_INPUTS 26
`define NUM_DEDICATED 4
`define RES_W 10
`define TRIG_SEL_W 5
`define HW_TRIG_W 32

`define SAMPLE_TADS 2
`define CONVERT_TADS 14
`define CNT_W 4

`define TRIG_NONE 5'h00
`define TRIG_SOFT 5'h01
`define TRIG_GLOBAL 5'h02

// Control register layout
`define CTRL_ADDR 8'h00
`define CTRL_ON_BIT 15
`define CTRL_GLOBAL_BIT 10
`define CTRL_ORDER_BIT 6
`define CTRL_ASYNC_BIT 4
// Per-pair control registers at PAIR_BASE + pair
`define PAIR_BASE 8'h10
`define PAIR_SOFT_BIT 7
`define PAIR_IRQEN_BIT 6
`define PAIR_PEND_BIT 5
// Pair interrupt flag and enable registers, and the result buffer base
`define IRQ_FLAG_ADDR 8'h01
`define IRQ_EN_ADDR 8'h02
`define RES_BASE 8'h40

`endif

// >>> logic/adc_seq_pkg.sv
// Types for the pair conversion sequencer
package adc_seq_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SAMPLE = 4'h2,
        ST_CONV_A = 4'h4,
        ST_CONV_B = 4'h8
    } seq_state_t;
endpackage

// >>> logic/adc_pair_conversion_sequencer.sv
// Pair-organised converter sequencer with register port and result buffers
//
// Overview of operation
// - Each conversion runs sample, then hold, then convert phases in order.
// - Synchronous mode samples only after a request, for 2 conversion clocks.
// - Each input converts in 14 conversion clock periods.
// - Asynchronous mode tracks dedicated inputs while idle, holds at once on request.
// - 26 inputs form 13 even/odd pairs; one whole pair per request.
// - Pairs 0 to 3 have a dedicated hold for the even input, zero latency.
// - Each pair has its own 5-bit trigger select field.
// - Sources: soft, global, PWM event, primaries, secondaries, limits, timers.
// - Select 0 none, 1 soft, 2 global, 3 PWM special event.
// - Simultaneous requests served in fixed priority, pair 0 first.
// - Pair soft trigger raises the request and clears itself on capture.
// - Global soft trigger, control bit 10, requests all global pairs, self-clears while the converter is on.
// - Each input result is stored in its own result buffer.
// - Completion sets the pair flag; pair interrupt only when enabled.
// - Pending bit set on request receipt, cleared on completion.
// - Completion of a pair with common enable raises the shared interrupt.
// - Converter works only while the on bit, control bit 15, is one.
// - A request during a conversion waits until the converter is idle.
// - Order bit 0 converts even input first, 1 converts odd first.
`timescale 1ns/1ps
`include "adc_seq_defs.svh"

module adc_pair_conversion_sequencer
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Hardware trigger sources, indexed by select code
    input wire logic [`HW_TRIG_W-1:0] hw_trigger,
    // Analog front end
    output logic [4:0] input_select,
    output logic shared_sample,
    output logic [`NUM_DEDICATED-1:0] dedicated_sample,
    output logic sar_start,
    input wire logic [`RES_W-1:0] sar_result,
    output logic analog_enable,
    // Interrupts
    output logic [`NUM_PAIRS-1:0] pair_irq,
    output logic common_converter_irq_flag
);
    // Control register and per-pair configuration
    logic converter_on_q;
    logic global_soft_trigger_q;
    logic order_q;
    logic free_running_sample_select_q;
    logic [`TRIG_SEL_W-1:0] pair_trigger_select_q [`NUM_PAIRS];
    logic [`NUM_PAIRS-1:0] pair_soft_trigger_q;
    logic [`NUM_PAIRS-1:0] pair_common_irq_enable_q;
    logic [`NUM_PAIRS-1:0] pair_conversion_pending_q;
    logic [`NUM_PAIRS-1:0] pair_irq_flag_q;
    logic [`NUM_PAIRS-1:0] pair_irq_enable_q;
    logic [`RES_W-1:0] result_buffer_q [`NUM_INPUTS];

    // Sequencer state
    adc_seq_pkg::seq_state_t state_q;
    logic [`CNT_W-1:0] cnt_q;
    logic [3:0] cur_pair_q;
    logic second_q;
    logic [`NUM_PAIRS-1:0] done_pulse;

    // Register decode
    wire ctrl_hit = reg_addr == `CTRL_ADDR;
    wire flag_hit = reg_addr == `IRQ_FLAG_ADDR;
    wire en_hit = reg_addr == `IRQ_EN_ADDR;
    wire [7:0] pair_off = reg_addr - `PAIR_BASE;
    wire pair_hit = (reg_addr >= `PAIR_BASE) && (pair_off < 8'(`NUM_PAIRS));
    wire [7:0] res_off = reg_addr - `RES_BASE;
    wire res_hit = (reg_addr >= `RES_BASE) && (res_off < 8'(`NUM_INPUTS));
    wire [3:0] pair_idx = pair_off[3:0];

    // Request capture per pair
    logic [`NUM_PAIRS-1:0] trig_raw;
    genvar g;
    generate
        for (g = 0; g < `NUM_PAIRS; g++)
        begin : gen_pair
            wire [`TRIG_SEL_W-1:0] sel = pair_trigger_select_q[g];
            // Codes 3 and up map straight onto the hardware trigger vector
            assign trig_raw[g] = converter_on_q && (
                (sel == `TRIG_SOFT && pair_soft_trigger_q[g]) ||
                (sel == `TRIG_GLOBAL && global_soft_trigger_q) ||
                (sel > `TRIG_GLOBAL && hw_trigger[sel]));
        end
    endgenerate

    // Fixed priority pick, lowest index wins
    logic [3:0] pick_idx;
    logic pick_valid;
    always_comb
    begin
        pick_idx = 4'h0;
        pick_valid = 1'b0;
        for (int i = `NUM_PAIRS - 1; i >= 0; i--)
        begin
            if (pair_conversion_pending_q[i])
            begin
                pick_idx = 4'(i);
                pick_valid = 1'b1;
            end
        end
    end

    wire idle = state_q == adc_seq_pkg::ST_IDLE;
    wire start = idle && pick_valid && converter_on_q;
    wire conv_end = (state_q == adc_seq_pkg::ST_CONV_A || state_q == adc_seq_pkg::ST_CONV_B)
        && cnt_q == `CNT_W'(`CONVERT_TADS - 1);
    wire pair_done = conv_end && second_q;
    wire first_odd = order_q;
    wire cur_odd = second_q ? !first_odd : first_odd;
    wire [4:0] cur_input = {cur_pair_q, cur_odd};
    wire dedicated_pair = cur_pair_q < 4'(`NUM_DEDICATED);

    always_comb
    begin
        done_pulse = '0;
        if (pair_done)
            done_pulse[cur_pair_q] = 1'b1;
    end

    // Conversion state machine
    always_ff @(posedge clk)
    begin
        if (!rst_n || !converter_on_q)
        begin
            state_q <= adc_seq_pkg::ST_IDLE;
            cnt_q <= '0;
            cur_pair_q <= '0;
            second_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                adc_seq_pkg::ST_IDLE:
                    if (start)
                    begin
                        cur_pair_q <= pick_idx;
                        second_q <= 1'b0;
                        cnt_q <= '0;
                        state_q <= adc_seq_pkg::ST_SAMPLE;
                    end
                adc_seq_pkg::ST_SAMPLE:
                    if (cnt_q == `CNT_W'(`SAMPLE_TADS - 1))
                    begin
                        cnt_q <= '0;
                        state_q <= adc_seq_pkg::ST_CONV_A;
                    end
                    else
                        cnt_q <= cnt_q + 1'b1;
                adc_seq_pkg::ST_CONV_A:
                    if (conv_end)
                    begin
                        cnt_q <= '0;
                        second_q <= 1'b1;
                        state_q <= adc_seq_pkg::ST_CONV_B;
                    end
                    else
                        cnt_q <= cnt_q + 1'b1;
                adc_seq_pkg::ST_CONV_B:
                    if (conv_end)
                    begin
                        cnt_q <= '0;
                        second_q <= 1'b0;
                        state_q <= adc_seq_pkg::ST_IDLE;
                    end
                    else
                        cnt_q <= cnt_q + 1'b1;
                default:
                    state_q <= adc_seq_pkg::ST_IDLE;
            endcase
        end
    end

    // Results land as each conversion ends; the second lands on the same edge that pending clears
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < `NUM_INPUTS; i++)
                result_buffer_q[i] <= '0;
        end
        else if (conv_end)
            result_buffer_q[cur_input] <= sar_result;
    end

    // Pending, flags and self-clearing triggers; set wins over clear
    wire wr_pair = reg_wr && pair_hit;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pair_conversion_pending_q <= '0;
            pair_irq_flag_q <= '0;
            pair_soft_trigger_q <= '0;
            global_soft_trigger_q <= 1'b0;
        end
        else
        begin
            pair_conversion_pending_q <= (pair_conversion_pending_q & ~done_pulse) | trig_raw;
            pair_irq_flag_q <= (pair_irq_flag_q & ~((reg_wr && flag_hit) ?
                reg_wdata[`NUM_PAIRS-1:0] : '0)) | done_pulse;
            for (int i = 0; i < `NUM_PAIRS; i++)
            begin
                if (wr_pair && pair_idx == 4'(i))
                    pair_soft_trigger_q[i] <= reg_wdata[`PAIR_SOFT_BIT];
                else if (trig_raw[i])
                    pair_soft_trigger_q[i] <= 1'b0;
            end
            if (reg_wr && ctrl_hit)
                global_soft_trigger_q <= reg_wdata[`CTRL_GLOBAL_BIT];
            else if (converter_on_q)
                global_soft_trigger_q <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            converter_on_q <= 1'b0;
            order_q <= 1'b0;
            free_running_sample_select_q <= 1'b0;
            pair_irq_enable_q <= '0;
            pair_common_irq_enable_q <= '0;
            for (int i = 0; i < `NUM_PAIRS; i++)
                pair_trigger_select_q[i] <= `TRIG_NONE;
        end
        else
        begin
            if (reg_wr && ctrl_hit)
            begin
                converter_on_q <= reg_wdata[`CTRL_ON_BIT];
                order_q <= reg_wdata[`CTRL_ORDER_BIT];
                free_running_sample_select_q <= reg_wdata[`CTRL_ASYNC_BIT];
            end
            if (reg_wr && en_hit)
                pair_irq_enable_q <= reg_wdata[`NUM_PAIRS-1:0];
            if (wr_pair)
            begin
                pair_trigger_select_q[pair_idx] <= reg_wdata[`TRIG_SEL_W-1:0];
                pair_common_irq_enable_q[pair_idx] <= reg_wdata[`PAIR_IRQEN_BIT];
            end
        end
    end

    // Read mux
    logic [15:0] rd_d;
    always_comb
    begin
        rd_d = 16'h0000;
        if (ctrl_hit)
        begin
            rd_d[`CTRL_ON_BIT] = converter_on_q;
            rd_d[`CTRL_GLOBAL_BIT] = global_soft_trigger_q;
            rd_d[`CTRL_ORDER_BIT] = order_q;
            rd_d[`CTRL_ASYNC_BIT] = free_running_sample_select_q;
        end
        else if (flag_hit)
            rd_d[`NUM_PAIRS-1:0] = pair_irq_flag_q;
        else if (en_hit)
            rd_d[`NUM_PAIRS-1:0] = pair_irq_enable_q;
        else if (pair_hit)
        begin
            rd_d[`TRIG_SEL_W-1:0] = pair_trigger_select_q[pair_idx];
            rd_d[`PAIR_SOFT_BIT] = pair_soft_trigger_q[pair_idx];
            rd_d[`PAIR_IRQEN_BIT] = pair_common_irq_enable_q[pair_idx];
            rd_d[`PAIR_PEND_BIT] = pair_conversion_pending_q[pair_idx];
        end
        else if (res_hit)
            rd_d[`RES_W-1:0] = result_buffer_q[res_off[4:0]];
    end

    // Async mode: dedicated holds track while idle, drop at once on the pick
    logic [`NUM_DEDICATED-1:0] ded_d;
    always_comb
    begin
        ded_d = '0;
        for (int i = 0; i < `NUM_DEDICATED; i++)
        begin
            if (free_running_sample_select_q && converter_on_q)
                ded_d[i] = idle && !(start && pick_idx == 4'(i));
            else if (state_q == adc_seq_pkg::ST_SAMPLE && cur_pair_q == 4'(i))
                ded_d[i] = 1'b1;
        end
    end

    // Registered outputs
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 16'h0000;
            input_select <= 5'h00;
            shared_sample <= 1'b0;
            dedicated_sample <= '0;
            sar_start <= 1'b0;
            analog_enable <= 1'b0;
            pair_irq <= '0;
            common_converter_irq_flag <= 1'b0;
        end
        else
        begin
            reg_rdata <= reg_rd ? rd_d : 16'h0000;
            input_select <= cur_input;
            shared_sample <= state_q == adc_seq_pkg::ST_SAMPLE && !dedicated_pair;
            dedicated_sample <= ded_d;
            sar_start <= state_q == adc_seq_pkg::ST_SAMPLE
                && cnt_q == `CNT_W'(`SAMPLE_TADS - 1);
            analog_enable <= converter_on_q;
            pair_irq <= done_pulse & pair_irq_enable_q;
            common_converter_irq_flag <= |(done_pulse & pair_common_irq_enable_q);
        end
    end

    // Checks
    // Switching off mid-phase is legal and aborts the phase
    sample_len_a: assert property (@(posedge clk) disable iff (!rst_n || !converter_on_q)
        $rose(state_q == adc_seq_pkg::ST_SAMPLE) |-> ##2 state_q == adc_seq_pkg::ST_CONV_A)
        else $error("sample phase not two cycles");
    conv_len_a: assert property (@(posedge clk) disable iff (!rst_n || !converter_on_q)
        $rose(state_q == adc_seq_pkg::ST_CONV_A) |->
        (state_q == adc_seq_pkg::ST_CONV_A)[*8] ##7 state_q == adc_seq_pkg::ST_CONV_B)
        else $error("conversion not fourteen cycles");
    prio_a: assert property (@(posedge clk) disable iff (!rst_n)
        start |-> (pair_conversion_pending_q & ~({`NUM_PAIRS{1'b1}} << pick_idx)) == '0)
        else $error("lower pair pending ahead of pick");
    pend_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        trig_raw[0] |=> pair_conversion_pending_q[0])
        else $error("pending not set");
    done_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        pair_done |=> pair_irq_flag_q[$past(cur_pair_q)]
        && (!pair_conversion_pending_q[$past(cur_pair_q)] || $past(trig_raw[cur_pair_q])))
        else $error("flag or pending wrong at completion");
    off_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        !converter_on_q |=> idle && !analog_enable)
        else $error("active while off");
    soft_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
        trig_raw[1] && !(wr_pair && pair_idx == 4'h1) |=> !pair_soft_trigger_q[1])
        else $error("soft trigger not cleared");
    wait_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        !idle |=> !$rose(state_q == adc_seq_pkg::ST_SAMPLE))
        else $error("new sample while busy");
    pair_conv_c: cover property (@(posedge clk) pair_done);
    two_req_c: cover property (@(posedge clk) $countones(trig_raw) > 1);
    async_c: cover property (@(posedge clk) free_running_sample_select_q && start);
endmodule // adc_pair_conversion_sequencer

// >>> sim/analog_front_end_model.sv
// Behavioural analog front end answering conversion starts
`timescale 1ns/1ps
`include "adc_seq_defs.svh"

module analog_front_end_model
#(
    parameter logic [9:0] SALT = 10'h2c6
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Converter side
    input wire logic [4:0] input_select,
    input wire logic sar_start,
    output logic [`RES_W-1:0] sar_result
);
    logic [5:0] window_q;
    logic [9:0] junk_q;

    // Junk outside a conversion so a late or early capture is seen
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            window_q <= 6'h00;
            junk_q <= 10'h000;
        end
        else
        begin
            junk_q <= junk_q + 10'h13b;
            if (sar_start)
                window_q <= 6'h1e;
            else if (window_q != 6'h00)
                window_q <= window_q - 6'h01;
        end
    end

    assign sar_result = (window_q != 6'h00) ? SALT ^ ({5'h00, input_select} * 10'h21)
        : junk_q;
endmodule // analog_front_end_model

// >>> sim/adc_pair_conversion_sequencer_tb_top.sv
// Self-checking bench for the pair conversion sequencer
`timescale 1ns/1ps
`include "adc_seq_defs.svh"

module adc_pair_conversion_sequencer_tb_top;
    localparam logic [9:0] SALT = 10'h2c6;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [31:0] hw_trigger = 32'h00000000;
    logic [4:0] input_select;
    logic shared_sample;
    logic [3:0] dedicated_sample;
    logic sar_start;
    logic [9:0] sar_result;
    logic analog_enable;
    logic [12:0] pair_irq;
    logic common_converter_irq_flag;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int irq_cnt[13];
    int common_cnt = 0;
    int ss_cnt = 0;
    logic chk = 1'b0;
    logic rd_d = 1'b0;
    logic [15:0] exp_q[$];
    logic [4:0] first_q[$];
    logic [7:0] res_list[4] = '{8'd4, 8'd5, 8'd10, 8'd11};

    always #5 clk = ~clk;

    adc_pair_conversion_sequencer uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .hw_trigger, .input_select, .shared_sample, .dedicated_sample,
        .sar_start, .sar_result, .analog_enable, .pair_irq, .common_converter_irq_flag);
    analog_front_end_model #(.SALT(SALT)) afe (.clk, .rst_n, .input_select, .sar_start,
        .sar_result);

    task automatic tally_and_finish;
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_compared++;
        if (seen !== want)
        begin
            num_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask

    function automatic logic [15:0] res(input int i);
        return {6'h00, SALT ^ (i[9:0] * 10'h21)};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Queued read: the watcher compares it when the data stand
    task automatic rd(input logic [7:0] a, input logic [15:0] want);
        exp_q.push_back(want);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        chk <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        chk <= 1'b0;
    endtask

    task automatic rd_raw(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        v = reg_rdata;
    endtask

    // Pending may lag the trigger, so see it set before waiting for clear
    task automatic wait_done(input logic [7:0] a);
        logic [15:0] v;
        v = 16'h0000;
        for (int n = 0; n < 8 && v[5] !== 1'b1; n++) rd_raw(a, v);
        check(v[5], 1'b1);
        for (int n = 0; n < 40 && v[5] !== 1'b0; n++) rd_raw(a, v);
        check(v[5], 1'b0);
    endtask

    task automatic pulse(input int code);
        @(posedge clk);
        hw_trigger <= $urandom | (32'h1 << code);
        @(posedge clk);
        hw_trigger <= 32'h00000000;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        rd_d <= reg_rd & chk;
        if (rd_d)
            check(reg_rdata, exp_q.pop_front());
        if (sar_start)
            check(input_select, first_q.pop_front());
        for (int p = 0; p < 13; p++) irq_cnt[p] += int'(pair_irq[p]);
        common_cnt += int'(common_converter_irq_flag);
        ss_cnt += int'(shared_sample);
        if (cycles == 4000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial
    begin
        logic [15:0] v;
        int code;
        void'($urandom(32'hbd5f));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(`CTRL_ADDR, 16'h0000);
        rd(`PAIR_BASE, 16'h0000);
        rd(8'h3f, 16'h0000);
        // Soft trigger on pair 0 with its pair interrupt enabled
        wr(`CTRL_ADDR, 16'h8000);
        wr(`IRQ_EN_ADDR, 16'h0001);
        check(analog_enable, 1'b1);
        first_q.push_back(5'd0);
        wr(`PAIR_BASE, 16'h0081);
        wait_done(`PAIR_BASE);
        rd(`PAIR_BASE, 16'h0001);
        for (int i = 0; i < 2; i++) rd(`RES_BASE + 8'(i), res(i));
        rd(`IRQ_FLAG_ADDR, 16'h0001);
        wr(`IRQ_FLAG_ADDR, 16'h0001);
        rd(`IRQ_FLAG_ADDR, 16'h0000);
        check(irq_cnt[0], 1);
        // Global trigger on pairs 5 and 2, odd input first
        wr(`PAIR_BASE + 8'd5, 16'h0042);
        wr(`PAIR_BASE + 8'd2, 16'h0002);
        first_q.push_back(5'd5);
        first_q.push_back(5'd11);
        wr(`CTRL_ADDR, 16'h8440);
        wait_done(`PAIR_BASE + 8'd5);
        rd(`CTRL_ADDR, 16'h8040);
        foreach (res_list[k]) rd(`RES_BASE + res_list[k], res(res_list[k]));
        rd(`IRQ_FLAG_ADDR, 16'h0024);
        check(common_cnt, 1);
        check(irq_cnt[2] + irq_cnt[5], 0);
        check(ss_cnt, 2);
        // Hardware source on the lowest priority pair
        wr(`CTRL_ADDR, 16'h8000);
        code = 3 + $urandom_range(28);
        wr(`PAIR_BASE + 8'd12, 16'(code));
        first_q.push_back(5'd24);
        pulse(code);
        wait_done(`PAIR_BASE + 8'd12);
        for (int i = 24; i < 26; i++) rd(`RES_BASE + 8'(i), res(i));
        check(ss_cnt, 4);
        // Free-running dedicated holds while idle
        wr(`CTRL_ADDR, 16'h8010);
        repeat (3) @(posedge clk);
        check(dedicated_sample, 4'hf);
        // Dedicated pair in free-running mode: holds drop before conversion
        first_q.push_back(5'd2);
        wr(`PAIR_BASE + 8'd1, 16'h0081);
        @(posedge clk iff sar_start == 1'b1);
        check(dedicated_sample, 4'h0);
        wait_done(`PAIR_BASE + 8'd1);
        for (int i = 2; i < 4; i++) rd(`RES_BASE + 8'(i), res(i));
        // Converter off refuses triggers
        wr(`CTRL_ADDR, 16'h0000);
        pulse(code);
        rd_raw(`PAIR_BASE + 8'd12, v);
        check(v, 16'(code));
        check(analog_enable, 1'b0);
        repeat (4) @(posedge clk);
        tally_and_finish();
    end
endmodule // adc_pair_conversion_sequencer_tb_top
